/* File: src/scs_pkg.sv */
// Purpose: shared types and constants of the system clock source selector
// Assumes: config word fields arrive as static levels from configuration storage
// Notes:   mode codes and status thresholds are local choices
package scs_pkg;

  // clock source modes held in the first configuration word
  typedef enum logic [2:0] {
    MODE_LOW_POWER_XTAL = 3'h0,
    MODE_MEDIUM_XTAL    = 3'h1,
    MODE_HIGH_XTAL      = 3'h2,
    MODE_EXT_CLOCK      = 3'h3,
    MODE_INT_OSC_IO     = 3'h4,
    MODE_INT_OSC        = 3'h5,
    MODE_RES_CAP_IO     = 3'h6,
    MODE_RES_CAP        = 3'h7
  } scs_mode_t;

  // start-up sequencer, one-hot
  typedef enum logic [2:0] {
    ST_CAPTURE = 3'h1,
    ST_COUNT   = 3'h2,
    ST_RUN     = 3'h4
  } scs_state_t;

  // drive of one pin towards the pad
  typedef struct packed {
    logic out;
    logic oe;
  } scs_pin_t;

  // divider select codes: 11 full rate, 10 half, 01 quarter, 00 eighth
  localparam logic [1:0] FSEL_DIV1    = 2'h3;
  localparam logic [1:0] FSEL_DIV2    = 2'h2;
  localparam logic [1:0] FSEL_DIV4    = 2'h1;
  localparam logic [1:0] FSEL_DIV8    = 2'h0;
  localparam logic [1:0] FSEL_RST     = FSEL_DIV2;
  localparam logic [2:0] PS_LAST      = 3'h7;

  // start-up oscillation count for the crystal modes
  localparam int         OST_COUNT    = 1024;
  localparam int         OST_W        = 10;
  localparam logic [9:0] OST_LAST     = 10'(OST_COUNT - 1);

  // clock output runs at the system rate divided by four
  localparam logic       CLKOUT_HALF  = 1'h1;

  // pin indices
  localparam int         PIN_CLKIN    = 0;
  localparam int         PIN_CLKOUT   = 1;

endpackage : scs_pkg

/* File: src/scs_postscaler.sv */
// Purpose: glitch-free divide by 1, 2, 4 or 8 of the internal source tick
// Assumes: src_tick is a one-cycle pulse on core_clk
// Notes:   a new select is applied only at the common divide-by-8 boundary
`timescale 1ns/1ps
module scs_postscaler
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // source and select
  input  wire logic       src_tick,
  input  wire logic [1:0] sel,
  // divided tick
  output logic            div_tick_ff
);

  logic [2:0] cnt_ff;
  logic [1:0] sel_ff;
  logic [2:0] mask;
  logic       boundary;
  logic       hit;

  // mask of counter bits that must be all ones for the selected divide
  assign mask     = (sel_ff == FSEL_DIV1) ? 3'h0 :
                    (sel_ff == FSEL_DIV2) ? 3'h1 :
                    (sel_ff == FSEL_DIV4) ? 3'h3 : 3'h7;
  assign boundary = src_tick && (cnt_ff == PS_LAST);
  assign hit      = src_tick && ((cnt_ff & mask) == mask);

  // switching only at the boundary keeps every output period whole
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff      <= 3'h0;
      sel_ff      <= FSEL_RST;
      div_tick_ff <= 1'h0;
    end
    else
    begin
      if (src_tick)
        cnt_ff <= cnt_ff + 3'h1;
      if (boundary)
        sel_ff <= sel;
      div_tick_ff <= hit;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_PS_FROM_SRC: assert property (div_tick_ff |-> $past(src_tick))
    else $error("divided tick without a source tick");
  AST_PS_FULL: assert property (
    (sel_ff == FSEL_DIV1) && src_tick |=> div_tick_ff)
    else $error("full-rate select skipped a source tick");
  AST_PS_ALIGN: assert property ($changed(sel_ff) |-> $past(cnt_ff) == PS_LAST)
    else $error("select changed off the aligned boundary");
  AST_PS_EIGHTH: assert property (
    (sel_ff == FSEL_DIV8) && $stable(sel_ff) && div_tick_ff |-> $past(cnt_ff) == PS_LAST)
    else $error("eighth-rate tick at the wrong count");

endmodule : scs_postscaler

/* File: src/scs_clock_select.sv */
// Purpose: clock source mode handling, internal divider and pin ownership
// Assumes: internal oscillator ticks are pulses on core_clk; pins are asynchronous
// Notes:   the system clock is represented by the one-cycle sys_tick pulse
`timescale 1ns/1ps
module scs_clock_select
  import scs_pkg::*;
#(
  parameter int LOCK_TICKS   = 64,
  parameter int STABLE_TICKS = 256
)
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // configuration storage
  input  scs_pkg::scs_mode_t     cfg_mode,
  input  wire logic              cfg_high_range,
  // software control
  input  wire logic              freq_sel_wr,
  input  wire logic [1:0]        freq_sel_wdata,
  input  wire logic              wake_req,
  // internal oscillator ticks
  input  wire logic              osc_hf_tick,
  input  wire logic              osc_lf_tick,
  // oscillator pins
  input  wire logic [1:0]        osc_pin_in,
  output scs_pkg::scs_pin_t      osc1_pin_drv,
  output scs_pkg::scs_pin_t      osc2_pin_drv,
  // general I/O user side
  input  scs_pkg::scs_pin_t [1:0] gpio_drv,
  output logic [1:0]             gpio_in,
  // status
  output logic [1:0]             freq_sel,
  output logic                   osc_locked,
  output logic                   osc_stable,
  output logic                   sys_tick,
  output logic                   exec_hold
);

  if (LOCK_TICKS < 1 || STABLE_TICKS < LOCK_TICKS || STABLE_TICKS > 4095)
  begin : g_bad_param
    $error("status tick thresholds out of range");
  end

  scs_state_t   state_ff;
  scs_state_t   nxt_state;
  scs_mode_t    mode_ff;
  logic         hr_ff;
  logic [1:0]   s1_ff;
  logic [1:0]   s2_ff;
  logic [1:0]   s3_ff;
  logic [1:0]   lvl_ff;
  logic [OST_W-1:0] ost_ff;
  logic [11:0]  stat_ff;
  logic         half_ff;
  logic         clkout_ff;
  logic         ps_tick;
  logic         src_tick;
  logic         clkin_rise;
  logic         is_int;
  logic         is_xtal;
  logic         is_rc;
  logic         drive_clkout;
  logic         osc1_gpio;
  logic         osc2_gpio;
  logic         tick_src;
  logic         ost_done;
  scs_pin_t     nxt_osc1;
  scs_pin_t     nxt_osc2;

  // three-stage synchronisers; a level counts once stages two and three agree
  for (genvar i = 0; i < 2; i++)
  begin : g_sync
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        s1_ff[i]  <= 1'h0;
        s2_ff[i]  <= 1'h0;
        s3_ff[i]  <= 1'h0;
        lvl_ff[i] <= 1'h0;
      end
      else
      begin
        s1_ff[i] <= osc_pin_in[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i])
          lvl_ff[i] <= s3_ff[i];
      end
    end
  end

  // mode decode from the captured configuration
  assign is_int    = (mode_ff == MODE_INT_OSC) || (mode_ff == MODE_INT_OSC_IO);
  assign is_rc     = (mode_ff == MODE_RES_CAP) || (mode_ff == MODE_RES_CAP_IO);
  assign is_xtal   = (mode_ff == MODE_LOW_POWER_XTAL) || (mode_ff == MODE_MEDIUM_XTAL) ||
                     (mode_ff == MODE_HIGH_XTAL);
  assign drive_clkout = (mode_ff == MODE_RES_CAP) || (mode_ff == MODE_INT_OSC);
  assign osc1_gpio = is_int;
  assign osc2_gpio = (mode_ff == MODE_RES_CAP_IO) || (mode_ff == MODE_INT_OSC_IO) ||
                     (mode_ff == MODE_EXT_CLOCK);

  // source ahead of the divider is fixed by the high-range bit
  assign src_tick   = hr_ff ? osc_hf_tick : osc_lf_tick;
  assign clkin_rise = (s2_ff[PIN_CLKIN] == s3_ff[PIN_CLKIN]) && s3_ff[PIN_CLKIN] &&
                      !lvl_ff[PIN_CLKIN];
  assign tick_src   = is_int ? ps_tick : clkin_rise;
  assign ost_done   = clkin_rise && (ost_ff == OST_LAST);

  // divider; the live oscillator keeps running so a new select needs no restart
  scs_postscaler u_postscaler (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .src_tick    (src_tick),
    .sel         (freq_sel),
    .div_tick_ff (ps_tick)
  );

  // pin ownership; crystal modes leave both pins to the resonator
  assign nxt_osc1 = osc1_gpio ? gpio_drv[PIN_CLKIN] : '0;
  assign nxt_osc2 = drive_clkout ? scs_pin_t'{out: clkout_ff, oe: 1'h1} :
                    osc2_gpio ? gpio_drv[PIN_CLKOUT] : '0;

  // sequencer: capture config, then count oscillations in crystal modes
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_CAPTURE: nxt_state = ST_RUN;
      ST_COUNT:   if (ost_done) nxt_state = ST_RUN;
      ST_RUN:     if (wake_req && is_xtal) nxt_state = ST_COUNT;
      default:    nxt_state = ST_CAPTURE;
    endcase
    if (state_ff == ST_CAPTURE && (cfg_mode == MODE_LOW_POWER_XTAL ||
        cfg_mode == MODE_MEDIUM_XTAL || cfg_mode == MODE_HIGH_XTAL))
      nxt_state = ST_COUNT;
  end

  // config is taken once after reset release and then held
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_CAPTURE;
      mode_ff  <= MODE_INT_OSC_IO;
      hr_ff    <= 1'h0;
      ost_ff   <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == ST_CAPTURE)
      begin
        mode_ff <= cfg_mode;
        hr_ff   <= cfg_high_range;
      end
      if (state_ff != ST_COUNT)
        ost_ff <= '0;
      else if (clkin_rise)
        ost_ff <= ost_ff + OST_W'(1);
    end
  end

  // software divider select, reset to half rate
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      freq_sel <= FSEL_RST;
    else if (freq_sel_wr)
      freq_sel <= freq_sel_wdata;
  end

  // oscillator status: saturating count of source ticks since reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_ff    <= 12'h0;
      osc_locked <= 1'h0;
      osc_stable <= 1'h0;
    end
    else
    begin
      if (src_tick && !osc_stable)
        stat_ff <= stat_ff + 12'h1;
      osc_locked <= osc_locked || (stat_ff >= 12'(LOCK_TICKS));
      osc_stable <= osc_stable || (stat_ff >= 12'(STABLE_TICKS));
    end
  end

  // system tick, clock output at a quarter of it, pin drives, status regs
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_tick     <= 1'h0;
      half_ff      <= 1'h0;
      clkout_ff    <= 1'h0;
      osc1_pin_drv <= '0;
      osc2_pin_drv <= '0;
      gpio_in      <= 2'h0;
      exec_hold    <= 1'h1;
    end
    else
    begin
      sys_tick <= tick_src;
      if (sys_tick)
      begin
        half_ff <= ~half_ff;
        if (half_ff == CLKOUT_HALF)
          clkout_ff <= ~clkout_ff;
      end
      osc1_pin_drv <= nxt_osc1;
      osc2_pin_drv <= nxt_osc2;
      gpio_in      <= lvl_ff;
      exec_hold    <= (nxt_state != ST_RUN);
    end
  end

  logic cfg_ok;
  logic run_seen_ff;
  // checks skip the capture edge and the one after it, where mode_ff may still move
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      run_seen_ff <= 1'h0;
    else
      run_seen_ff <= (state_ff != ST_CAPTURE);
  end
  assign cfg_ok = (state_ff != ST_CAPTURE) && run_seen_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_MODE_HELD: assert property (cfg_ok |-> $stable(mode_ff) && $stable(hr_ff))
    else $error("configuration changed while running");
  AST_RESET_SEL: assert property ($past(state_ff == ST_CAPTURE) && !$past(freq_sel_wr)
    |-> freq_sel == FSEL_RST)
    else $error("divider select not at reset value");
  AST_SEL_WRITE: assert property (freq_sel_wr |=> freq_sel == $past(freq_sel_wdata))
    else $error("divider select write lost");
  AST_RC_OUT: assert property (cfg_ok && mode_ff == MODE_RES_CAP |=>
    osc2_pin_drv.oe && osc2_pin_drv.out == $past(clkout_ff))
    else $error("clock output not driven in resistor-capacitor mode");
  AST_IO_OUT: assert property (cfg_ok && osc2_gpio |=> osc2_pin_drv == $past(gpio_drv[1]))
    else $error("clock output pin not released to general I/O");
  AST_EXT_IN: assert property (cfg_ok && mode_ff == MODE_EXT_CLOCK |=>
    !osc1_pin_drv.oe && osc2_pin_drv == $past(gpio_drv[1]))
    else $error("external clock pins misassigned");
  AST_INT_IO: assert property (cfg_ok && is_int |=> osc1_pin_drv == $past(gpio_drv[0]))
    else $error("clock input pin not released in internal modes");
  AST_QUARTER: assert property ($changed(clkout_ff) |-> $past(sys_tick && half_ff))
    else $error("clock output edge off the quarter point");
  AST_INT_TICK: assert property (cfg_ok && is_int && sys_tick |-> $past(ps_tick))
    else $error("internal mode tick not from the divider");
  AST_HOLD_COUNT: assert property (state_ff == ST_COUNT ##1 state_ff == ST_RUN
    |-> $past(ost_ff) == OST_LAST && $past(clkin_rise))
    else $error("execution released before full oscillation count");
  AST_HOLD_OUT: assert property (state_ff == ST_COUNT |-> exec_hold)
    else $error("execution not held while counting");
  AST_FLAGS: assert property (osc_stable |-> osc_locked)
    else $error("stable flag without locked flag");

  COV_COUNT_DONE: cover property (state_ff == ST_COUNT ##1 state_ff == ST_RUN);
  COV_SEL_WRITE:  cover property (freq_sel_wr && freq_sel_wdata == FSEL_DIV8);
  COV_CLKOUT:     cover property (drive_clkout && $rose(clkout_ff));
  COV_STABLE:     cover property ($rose(osc_stable));

endmodule : scs_clock_select

/* File: tb/scs_ext_osc.sv */
// Purpose: far-side model, resonator or clock source on the oscillator pins
// Assumes: the device pin drives are registered on core_clk
// Notes:   undriven pins show a pattern that changes every cycle, except the input pin, which shows the source clock while running
`timescale 1ns/1ps
module scs_ext_osc
  import scs_pkg::*;
(
  // clock and control
  input  wire logic         core_clk,
  input  wire logic         run,
  // device pin drives
  input  scs_pkg::scs_pin_t osc1_drv,
  input  scs_pkg::scs_pin_t osc2_drv,
  // resolved pin levels and rising edge count
  output logic [1:0]        pin_lvl,
  output int                edge_cnt
);
  import scs_pkg::*;
  logic       clk_ff  = 1'h0;
  logic [2:0] ph_ff   = 3'h0;
  logic [1:0] last_ff = 2'h0;
  initial edge_cnt = 0;

  // a driving device wins; otherwise the source clock, or a changing pattern when released
  assign pin_lvl[0] = osc1_drv.oe ? osc1_drv.out : (run ? clk_ff : ~last_ff[0]);
  assign pin_lvl[1] = osc2_drv.oe ? osc2_drv.out : ~last_ff[1];

  // logic-level clock, 4 cycles high and 4 low, stands still while stopped
  always @(posedge core_clk)
  begin
    last_ff <= pin_lvl;
    if (run)
    begin
      ph_ff <= ph_ff + 3'h1;
      if (ph_ff == 3'h3 || ph_ff == 3'h7)
      begin
        clk_ff <= ~clk_ff;
        if (!clk_ff) edge_cnt <= edge_cnt + 1;
      end
    end
  end
endmodule : scs_ext_osc

/* File: tb/testbench.sv */
// Purpose: self-checking bench of the clock source selector
// Assumes: hf source ticks every cycle, lf source every fourth cycle
// Notes:   windows count sys_tick pulses and clock-out toggles; short flag counts
`timescale 1ns/1ps
module testbench;
  import scs_pkg::*;
  typedef struct { string nm; int ticks; int togs; } scs_exp_t;
  localparam logic [7:0] O1OE  = 8'h30; // internal modes own the input pin
  localparam logic [7:0] O2OE  = 8'hF8;
  localparam logic [7:0] GPIO2 = 8'h58;
  localparam logic [7:0] CLKO  = 8'hA0;
  localparam int         TICKS [8] = '{0, 0, 0, 8, 32, 32, 8, 8};
  logic core_clk, rst_n, cfg_high_range, freq_sel_wr, wake_req, osc_hf_tick, osc_lf_tick;
  logic ext_run, win_clr, win_done, tog_prev, osc_locked, osc_stable, sys_tick, exec_hold;
  logic [1:0] freq_sel_wdata, osc_pin_in, gpio_in, freq_sel, lf_div, g;
  scs_mode_t cfg_mode;
  scs_pin_t  osc1_pin_drv, osc2_pin_drv;
  scs_pin_t [1:0] gpio_drv;
  int errors = 0, n_checks = 0, tick_cnt, tog_cnt, edge_cnt, base;
  scs_exp_t exp_q[$];
  scs_exp_t e_cur;

  scs_clock_select #(.LOCK_TICKS(4), .STABLE_TICKS(8)) scs_clock_select_i (
    .core_clk(core_clk), .rst_n(rst_n), .cfg_mode(cfg_mode), .cfg_high_range(cfg_high_range),
    .freq_sel_wr(freq_sel_wr), .freq_sel_wdata(freq_sel_wdata), .wake_req(wake_req),
    .osc_hf_tick(osc_hf_tick), .osc_lf_tick(osc_lf_tick), .osc_pin_in(osc_pin_in),
    .osc1_pin_drv(osc1_pin_drv), .osc2_pin_drv(osc2_pin_drv), .gpio_drv(gpio_drv),
    .gpio_in(gpio_in), .freq_sel(freq_sel), .osc_locked(osc_locked),
    .osc_stable(osc_stable), .sys_tick(sys_tick), .exec_hold(exec_hold));
  scs_ext_osc scs_ext_osc_i (.core_clk(core_clk), .run(ext_run), .osc1_drv(osc1_pin_drv),
    .osc2_drv(osc2_pin_drv), .pin_lvl(osc_pin_in), .edge_cnt(edge_cnt));

  initial
  begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end

  // internal oscillator sources, free running
  always @(posedge core_clk)
  begin
    osc_hf_tick <= 1'h1;
    lf_div <= lf_div + 2'h1;
    osc_lf_tick <= (lf_div == 2'h3);
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // monitor: counts pulses and toggles, compares against the oldest note at window end
  always @(posedge core_clk)
  begin
    tog_prev <= osc2_pin_drv.out;
    tick_cnt <= win_clr ? 0 : tick_cnt + int'(sys_tick === 1'h1);
    tog_cnt <= win_clr ? 0 : tog_cnt + int'(osc2_pin_drv.out !== tog_prev);
    if (win_done)
    begin
      e_cur = exp_q.pop_front();
      chk({e_cur.nm, " ticks"}, tick_cnt, e_cur.ticks);
      chk({e_cur.nm, " clkout toggles"}, tog_cnt, e_cur.togs);
    end
  end

  task automatic do_reset(input scs_mode_t m, input logic hr);
    rst_n <= 1'h0;
    cfg_mode <= m;
    cfg_high_range <= hr;
    ext_run <= !(m inside {MODE_INT_OSC_IO, MODE_INT_OSC});
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
  endtask : do_reset

  task automatic win(input string nm, input int n, input int ticks, input int togs);
    win_clr <= 1'h1;
    @(posedge core_clk);
    win_clr <= 1'h0;
    repeat (n) @(posedge core_clk);
    exp_q.push_back('{nm, ticks, togs});
    win_done <= 1'h1;
    @(posedge core_clk);
    win_done <= 1'h0;
  endtask : win

  task automatic wr(input logic [1:0] s);
    freq_sel_wr <= 1'h1;
    freq_sel_wdata <= s;
    @(posedge core_clk);
    freq_sel_wr <= 1'h0;
  endtask : wr

  task automatic wait_edges(input int tgt);
    int k;
    k = 0;
    while (edge_cnt < tgt && k < 20000)
    begin
      @(posedge core_clk);
      k++;
    end
    if (k == 20000)
    begin
      errors++;
      summarize();
    end
  endtask : wait_edges

  initial
  begin
    {rst_n, cfg_high_range, freq_sel_wr, wake_req, ext_run, win_clr, win_done} = 7'h00;
    {freq_sel_wdata, lf_div, tog_prev, tick_cnt, tog_cnt} = '0;
    {osc_hf_tick, osc_lf_tick} = 2'h0;
    cfg_mode = MODE_INT_OSC;
    gpio_drv = '0;
    void'($urandom(99536));
    // high range: reset value, back-to-back writes, every divider code
    do_reset(MODE_INT_OSC, 1'h1);
    #1 chk("freq_sel reset", freq_sel, FSEL_RST);
    @(posedge core_clk);
    freq_sel_wr <= 1'h1;
    freq_sel_wdata <= FSEL_DIV8;
    @(posedge core_clk);
    freq_sel_wdata <= FSEL_DIV1;
    @(posedge core_clk);
    freq_sel_wr <= 1'h0;
    repeat (16) @(posedge core_clk);
    #1 chk("freq_sel last write", freq_sel, FSEL_DIV1);
    win("div1 after burst", 64, 64, 32);
    for (int s = 0; s < 4; s++)
    begin
      wr(2'(s));
      repeat (16) @(posedge core_clk);
      chk("freq_sel", freq_sel, 32'(s));
      win("high range", 64, 64 >> (3 - s), 32 >> (3 - s));
    end
    $display("test high range done");
    // low range with status flags; config change without reset is ignored
    do_reset(MODE_INT_OSC, 1'h0);
    #1 chk("locked early", osc_locked, 1'h0);
    chk("stable early", osc_stable, 1'h0);
    repeat (19) @(posedge core_clk);
    #1 chk("locked mid", osc_locked, 1'h1);
    chk("stable mid", osc_stable, 1'h0);
    repeat (40) @(posedge core_clk);
    #1 chk("stable late", osc_stable, 1'h1);
    win("low range reset select", 256, 32, 16);
    cfg_high_range <= 1'h1;
    wr(FSEL_DIV1);
    repeat (40) @(posedge core_clk);
    win("low range full", 256, 64, 32);
    $display("test low range done");
    // every clock source mode: pin ownership and clock out; tick source outside the crystal modes
    for (int m = 0; m < 8; m++)
    begin
      @(posedge core_clk);
      g = 2'($urandom);
      gpio_drv <= {g[1], 1'h1, g[0], 1'h1};
      do_reset(scs_mode_t'(m), 1'h1);
      repeat (32) @(posedge core_clk);
      #1 chk("osc1 oe", osc1_pin_drv.oe, O1OE[m]);
      chk("osc2 oe", osc2_pin_drv.oe, O2OE[m]);
      chk("exec_hold", exec_hold, 1'(m < 3));
      if (O1OE[m]) chk("gpio_in0", gpio_in[0], g[0]);
      if (GPIO2[m]) chk("osc2 out", osc2_pin_drv.out, g[1]);
      if (GPIO2[m]) chk("gpio_in1", gpio_in[1], g[1]);
      if (m >= 3) win("mode", 64, TICKS[m], CLKO[m] ? TICKS[m] / 2 : 0);
    end
    $display("test modes done");
    // crystal start-up count, then again after a wake
    do_reset(MODE_HIGH_XTAL, 1'h1);
    for (int w = 0; w < 2; w++)
    begin
      if (w == 1)
      begin
        @(posedge core_clk);
        wake_req <= 1'h1;
        @(posedge core_clk);
        wake_req <= 1'h0;
      end
      base = edge_cnt;
      wait_edges(base + 1020);
      #1 chk("exec_hold counting", exec_hold, 1'h1);
      wait_edges(base + 1030);
      #1 chk("exec_hold released", exec_hold, 1'h0);
    end
    $display("test start-up count done");
    summarize();
  end
endmodule : testbench
